// ---- src/t16pm_defines.vh ----
// Constants for the 16-bit pulse/PWM timer: register offsets, field positions,
// reset values and counter reload values. Included by t16pm_timer.v only.
`ifndef T16PM_DEFINES_VH
`define T16PM_DEFINES_VH

// Register byte offsets (APB, one word each)
`define T16PM_OFF_CTRL1     12'h000
`define T16PM_OFF_CTRL2     12'h004
`define T16PM_OFF_STATUS    12'h008
`define T16PM_OFF_COUNT     12'h00C
`define T16PM_OFF_CMP1_HI   12'h010
`define T16PM_OFF_CMP1_LO   12'h014
`define T16PM_OFF_CMP2_HI   12'h018
`define T16PM_OFF_CMP2_LO   12'h01C
`define T16PM_OFF_CAP1      12'h020
`define T16PM_OFF_CAP2      12'h024
`define T16PM_OFF_LAST      12'h024

// Control one fields
`define T16PM_C1_CAP_IE     7
`define T16PM_C1_CMP_IE     6
`define T16PM_C1_OVF_IE     5
`define T16PM_C1_FORCE2     4
`define T16PM_C1_FORCE1     3
`define T16PM_C1_LEVEL2     2
`define T16PM_C1_TRIG_EDGE  1
`define T16PM_C1_LEVEL1     0

// Control two fields
`define T16PM_C2_PIN1_EN    7
`define T16PM_C2_PIN2_EN    6
`define T16PM_C2_SINGLE     5
`define T16PM_C2_PWM        4
`define T16PM_C2_TICK_HI    3
`define T16PM_C2_TICK_LO    2
`define T16PM_C2_CAP2_EDGE  1
`define T16PM_C2_EXT_EDGE   0

// Status flag positions
`define T16PM_ST_CAP1       0
`define T16PM_ST_CAP2       1
`define T16PM_ST_CMP1       2
`define T16PM_ST_CMP2       3
`define T16PM_ST_OVF        4

// Tick select encodings
`define T16PM_TICK_DIV4     2'h0
`define T16PM_TICK_DIV2     2'h1
`define T16PM_TICK_DIV8     2'h2
`define T16PM_TICK_EXT      2'h3

// Reset, reload and top values
`define T16PM_CTRL_RESET    8'h00
`define T16PM_CMP_RESET     16'h8000
`define T16PM_CNT_RELOAD    16'hFFFC
`define T16PM_CNT_RESET     16'hFFFC
`define T16PM_CNT_TOP       16'hFFFF

`endif

// ---- src/t16pm_timer.v ----
// 16-bit free-running timer with one-pulse and PWM modes, APB register slave.
// Assumes pin inputs are asynchronous; wait, halt and mask levels come from
// core logic on core_clk.
`include "t16pm_defines.vh"

module t16pm_timer (
    // Clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Pins
    input  wire        trigger_capture_one_pin,
    input  wire        capture_two_pin,
    input  wire        external_tick_pin,
    output reg         compare_one_out_pin,
    output wire        compare_one_out_en,
    output reg         compare_two_out_pin,
    output wire        compare_two_out_en,
    // Processor power and interrupt state
    input  wire        cpu_irq_mask,
    input  wire        wait_state,
    input  wire        halt_state,
    output reg         irq_request,
    output reg         wake_from_wait
);

    // Prescaler taps: the free-running 3-bit count gives one tick every 2, 4
    // or 8 core cycles; the external setting never ticks from here
    function tick_due;
        input [1:0] sel;
        input [2:0] presc;
        begin
            case (sel)
                `T16PM_TICK_DIV2: tick_due = presc[0];
                `T16PM_TICK_DIV4: tick_due = &presc[1:0];
                `T16PM_TICK_DIV8: tick_due = &presc;
                default:          tick_due = 1'b0;
            endcase
        end
    endfunction

    // Word-aligned offsets inside the map only; anything else is refused
    // with pslverr and neither writes nor returns data
    function addr_hit;
        input [11:0] a;
        begin
            addr_hit = (a[1:0] == 2'h0) && (a <= `T16PM_OFF_LAST);
        end
    endfunction

    reg  [7:0]  ctrl1;
    reg  [7:0]  ctrl2;
    reg  [4:0]  flags;
    reg  [15:0] count;
    reg  [15:0] compare_one_value;
    reg  [15:0] compare_two_value;
    reg  [15:0] shadow_one;
    reg  [15:0] shadow_two;
    reg  [1:0]  hi_lock;
    reg  [15:0] capture_one_value;
    reg  [15:0] capture_two_value;
    reg  [2:0]  presc;
    reg  [1:0]  halt_arm;
    reg         halt_q;

    wire [2:0]  pin_rise;
    wire [2:0]  pin_fall;
    wire [2:0]  pin_raw = {external_tick_pin, capture_two_pin, trigger_capture_one_pin};

    // Three-stage synchronisers; a change counts once stages two and three agree
    // Edges come from the agreed level, so a glitch seen by one stage alone
    // never reaches the tick, trigger or capture logic
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            reg s1;
            reg s2;
            reg s3;
            reg stable;
            always @(posedge core_clk) begin
                if (srst) begin
                    s1     <= 1'b0;
                    s2     <= 1'b0;
                    s3     <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        stable <= s3;
                end
            end
            assign pin_rise[g] = s2 & s3 & ~stable;
            assign pin_fall[g] = ~s2 & ~s3 & stable;
        end
    endgenerate

    // PWM wins over one-pulse; with neither set the timer is plain capture
    // and compare
    wire pwm_mode    = ctrl2[`T16PM_C2_PWM];
    wire single_mode = ctrl2[`T16PM_C2_SINGLE] & ~pwm_mode;
    wire plain_mode  = ~pwm_mode & ~single_mode;
    wire [1:0] tick_select = ctrl2[`T16PM_C2_TICK_HI:`T16PM_C2_TICK_LO];
    wire level_one_bit = ctrl1[`T16PM_C1_LEVEL1];
    wire level_two_bit = ctrl1[`T16PM_C1_LEVEL2];
    wire levels_equal  = (level_one_bit == level_two_bit);

    // Timer tick: prescaled clock or selected external edge, none during halt
    wire ext_edge = ctrl2[`T16PM_C2_EXT_EDGE] ? pin_rise[2] : pin_fall[2];
    wire tick = ~halt_state & ((tick_select == `T16PM_TICK_EXT) ? ext_edge
                                                                : tick_due(tick_select, presc));

    // PWM compares against the shadows; other modes against the live values
    wire [15:0] act_one = pwm_mode ? shadow_one : compare_one_value;
    wire [15:0] act_two = pwm_mode ? shadow_two : compare_two_value;
    // A pending high byte inhibits ordinary compares, never the PWM ones
    wire match_one = tick & (count == act_one) & (pwm_mode | ~hi_lock[0]);
    wire match_two = tick & (count == act_two) & (pwm_mode | ~hi_lock[1]);

    wire trig_edge = ctrl1[`T16PM_C1_TRIG_EDGE] ? pin_rise[0] : pin_fall[0];
    wire cap2_edge = ctrl2[`T16PM_C2_CAP2_EDGE] ? pin_rise[1] : pin_fall[1];
    wire single_trig = single_mode & trig_edge & ~halt_state;
    wire pwm_end     = pwm_mode & match_two;
    // Interrupt wake-up from halt; a reset wake-up goes through srst instead
    wire halt_exit   = halt_q & ~halt_state;

    // Flag set conditions; PWM and one-pulse keep the compare flags quiet
    // where the mode owns the compare
    wire [4:0] flag_set;
    assign flag_set[`T16PM_ST_CAP1] = (~pwm_mode & trig_edge & ~halt_state)
                                    | pwm_end
                                    | (halt_exit & halt_arm[0]);
    assign flag_set[`T16PM_ST_CAP2] = (cap2_edge & ~halt_state) | (halt_exit & halt_arm[1]);
    assign flag_set[`T16PM_ST_CMP1] = match_one & plain_mode;
    assign flag_set[`T16PM_ST_CMP2] = match_two & ~pwm_mode;
    // No overflow on a reload cycle: the count never passes FFFF then.
    // A PWM period does pass FFFF after its reload, so overflow still fires.
    assign flag_set[`T16PM_ST_OVF]  = tick & (count == `T16PM_CNT_TOP) & ~pwm_end & ~single_trig;

    // APB
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pwrite & addr_hit(paddr);
    wire [4:0] flag_clr = (apb_wr && paddr == `T16PM_OFF_STATUS) ? pwdata[4:0] : 5'h00;

    // Zero-wait slave: read data is latched in the setup cycle and stands
    // through the access phase, so a count read shows the setup-cycle value.
    // Masters that insert extra setup cycles simply reload it.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit(paddr);

    always @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            case (paddr)
                `T16PM_OFF_CTRL1:   prdata <= {24'h000000, ctrl1};
                `T16PM_OFF_CTRL2:   prdata <= {24'h000000, ctrl2};
                `T16PM_OFF_STATUS:  prdata <= {27'h0000000, flags};
                `T16PM_OFF_COUNT:   prdata <= {16'h0000, count};
                `T16PM_OFF_CMP1_HI: prdata <= {24'h000000, compare_one_value[15:8]};
                `T16PM_OFF_CMP1_LO: prdata <= {24'h000000, compare_one_value[7:0]};
                `T16PM_OFF_CMP2_HI: prdata <= {24'h000000, compare_two_value[15:8]};
                `T16PM_OFF_CMP2_LO: prdata <= {24'h000000, compare_two_value[7:0]};
                `T16PM_OFF_CAP1:    prdata <= {16'h0000, capture_one_value};
                `T16PM_OFF_CAP2:    prdata <= {16'h0000, capture_two_value};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control and compare registers
    // A high-byte write leaves the word half old, half new; the lock keeps
    // that mixed value out of the shadows until the low byte follows
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl1             <= `T16PM_CTRL_RESET;
            ctrl2             <= `T16PM_CTRL_RESET;
            compare_one_value <= `T16PM_CMP_RESET;
            compare_two_value <= `T16PM_CMP_RESET;
            hi_lock           <= 2'h0;
        end else if (apb_wr) begin
            case (paddr)
                `T16PM_OFF_CTRL1: ctrl1 <= pwdata[7:0];
                `T16PM_OFF_CTRL2: ctrl2 <= pwdata[7:0];
                `T16PM_OFF_CMP1_HI: begin
                    compare_one_value[15:8] <= pwdata[7:0];
                    hi_lock[0]              <= 1'b1;
                end
                `T16PM_OFF_CMP1_LO: begin
                    compare_one_value[7:0] <= pwdata[7:0];
                    hi_lock[0]             <= 1'b0;
                end
                `T16PM_OFF_CMP2_HI: begin
                    compare_two_value[15:8] <= pwdata[7:0];
                    hi_lock[1]              <= 1'b1;
                end
                `T16PM_OFF_CMP2_LO: begin
                    compare_two_value[7:0] <= pwdata[7:0];
                    hi_lock[1]             <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // Shadows track the live values outside PWM, so entering PWM starts clean
    always @(posedge core_clk) begin
        if (srst) begin
            shadow_one <= `T16PM_CMP_RESET;
            shadow_two <= `T16PM_CMP_RESET;
        end else begin
            if ((~pwm_mode | pwm_end) & ~hi_lock[0])
                shadow_one <= compare_one_value;
            if ((~pwm_mode | pwm_end) & ~hi_lock[1])
                shadow_two <= compare_two_value;
        end
    end

    // Prescaler and counter; both hold still in halt
    // A reload in the same cycle as a tick wins, so every new period starts
    // exactly at the reload value
    always @(posedge core_clk) begin
        if (srst) begin
            presc  <= 3'h0;
            count  <= `T16PM_CNT_RESET;
            halt_q <= 1'b0;
        end else begin
            halt_q <= halt_state;
            if (!halt_state)
                presc <= presc + 3'h1;
            if (single_trig)
                count <= `T16PM_CNT_RELOAD;
            else if (pwm_end)
                count <= `T16PM_CNT_RELOAD;
            else if (tick)
                count <= count + 16'h0001;
        end
    end

    // Capture registers and halt arming
    // In halt an edge only arms; the capture waits for the exit so that it
    // holds the count present when the timer wakes
    always @(posedge core_clk) begin
        if (srst) begin
            capture_one_value <= 16'h0000;
            capture_two_value <= 16'h0000;
            halt_arm          <= 2'h0;
        end else begin
            if (halt_exit) begin
                halt_arm <= 2'h0;
                if (halt_arm[0])
                    capture_one_value <= count;
                if (halt_arm[1])
                    capture_two_value <= count;
            end else if (halt_state) begin
                // Pin one is not a capture input in PWM mode
                if (trig_edge & ~pwm_mode)
                    halt_arm[0] <= 1'b1;
                if (cap2_edge)
                    halt_arm[1] <= 1'b1;
            end else begin
                if (trig_edge & ~pwm_mode)
                    capture_one_value <= count;
                if (cap2_edge)
                    capture_two_value <= count;
            end
        end
    end

    // Status flags; a hardware set wins over a software clear in the same cycle
    // so an event landing on the clear write is never lost
    always @(posedge core_clk) begin
        if (srst)
            flags <= 5'h00;
        else
            flags <= (flags & ~flag_clr) | flag_set;
    end

    // Compare one output pin
    // In PWM and one-pulse modes equal levels win over every event, so the pin holds one constant level
    // while the mode keeps running underneath
    always @(posedge core_clk) begin
        if (srst) begin
            compare_one_out_pin <= 1'b0;
        end else if (pwm_mode) begin
            if (levels_equal)
                compare_one_out_pin <= level_one_bit;
            else if (pwm_end)
                compare_one_out_pin <= level_two_bit;
            else if (match_one)
                compare_one_out_pin <= level_one_bit;
        end else if (single_mode) begin
            if (levels_equal)
                compare_one_out_pin <= level_one_bit;
            else if (single_trig)
                compare_one_out_pin <= level_two_bit;
            else if (match_one)
                compare_one_out_pin <= level_one_bit;
        end else if (match_one | ctrl1[`T16PM_C1_FORCE1]) begin
            compare_one_out_pin <= level_one_bit;
        end
    end

    // Compare two output pin: only ordinary output compare drives it
    // Its level bit belongs to pin one in the pulse modes, so the pin stays put
    always @(posedge core_clk) begin
        if (srst)
            compare_two_out_pin <= 1'b0;
        else if (plain_mode & (match_two | ctrl1[`T16PM_C1_FORCE2]))
            compare_two_out_pin <= level_two_bit;
    end

    assign compare_one_out_en = ctrl2[`T16PM_C2_PIN1_EN];
    assign compare_two_out_en = ctrl2[`T16PM_C2_PIN2_EN];

    // Shared interrupt request; wake only from wait, never from halt
    // Registered so the request follows the flags one cycle later and never
    // glitches when several events arrive together
    wire cap_req = (flags[`T16PM_ST_CAP1] | flags[`T16PM_ST_CAP2]) & ctrl1[`T16PM_C1_CAP_IE];
    wire cmp_req = (flags[`T16PM_ST_CMP1] | flags[`T16PM_ST_CMP2]) & ctrl1[`T16PM_C1_CMP_IE];
    wire ovf_req = flags[`T16PM_ST_OVF] & ctrl1[`T16PM_C1_OVF_IE];
    wire next_irq = (cap_req | cmp_req | ovf_req) & ~cpu_irq_mask;

    always @(posedge core_clk) begin
        if (srst) begin
            irq_request    <= 1'b0;
            wake_from_wait <= 1'b0;
        end else begin
            irq_request    <= next_irq;
            wake_from_wait <= next_irq & wait_state;
        end
    end

endmodule // t16pm_timer

// ---- verif/t16pm_pin_model.sv ----
// Trigger source, external tick source and load on compare pin one.
// Pin levels change just after a rising edge of core_clk.
module t16pm_pin_model (
    // Commands
    input  logic core_clk,
    input  logic trig_level,
    input  logic cap2_level,
    input  logic ext_run,
    // Pins
    input  logic compare_one_out_pin,
    output logic trigger_capture_one_pin,
    output logic capture_two_pin,
    output logic external_tick_pin,
    // Measured waveform, in core cycles
    output int   high_len,
    output int   low_len,
    output int   rises
);
    logic [2:0] phase;
    logic       last;
    int         run;
    initial begin
        {trigger_capture_one_pin, capture_two_pin, external_tick_pin, phase, last} = 7'h00;
        {high_len, low_len, rises, run} = {4{32'sd0}};
    end
    // External tick stands still outside its run, one rising edge each 8 cycles
    always @(posedge core_clk) begin
        trigger_capture_one_pin <= trig_level;
        capture_two_pin <= cap2_level;
        if (ext_run) phase <= phase + 3'h1;
        external_tick_pin <= phase[2];
        last <= compare_one_out_pin;
        if (compare_one_out_pin !== last) begin
            if (last) high_len <= run;
            else low_len <= run;
            if (compare_one_out_pin) rises <= rises + 1;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
endmodule // t16pm_pin_model

// ---- verif/t16pm_timer_props.sv ----
// Port checker for the pulse/PWM timer.
// Bound to t16pm_timer; mirrors control writes seen on APB.
module t16pm_timer_props (
    // Clock and reset
    input logic        core_clk,
    input logic        srst,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pslverr,
    // Pins and core state
    input logic        compare_one_out_pin,
    input logic        compare_one_out_en,
    input logic        compare_two_out_pin,
    input logic        cpu_irq_mask,
    input logic        wait_state,
    input logic        irq_request,
    input logic        wake_from_wait
);
    logic [7:0] c1;
    logic [7:0] c2;
    logic [1:0] age;
    wire        wr_any = psel && penable && pwrite;
    wire        eq_mode = (c2[5] | c2[4]) && (c1[0] == c1[2]);
    wire        one_mode = c2[5] && !c2[4];
    wire        no_ie = c1[7:5] == 3'h0;
    // Age gives registered outputs time to settle after a mode change
    always_ff @(posedge core_clk) begin
        if (srst) begin
            c1 <= 8'h00;
            c2 <= 8'h00;
            age <= 2'h0;
        end else if (wr_any && (paddr == 12'h000 || paddr == 12'h004)) begin
            if (paddr == 12'h000) c1 <= pwdata[7:0];
            if (paddr == 12'h004) c2 <= pwdata[7:0];
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    a_reset_quiet: assert property (srst |=> !irq_request && !compare_one_out_pin && prdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_mask_blocks: assert property (disable iff (srst) $past(cpu_irq_mask) |-> !irq_request)
        else $error("request raised while masked");
    a_enable_gates: assert property (disable iff (srst) no_ie && $past(no_ie) |-> !irq_request)
        else $error("request raised with all enables off");
    a_wake_wait: assert property (disable iff (srst) !$past(wait_state) |-> !wake_from_wait)
        else $error("wake outside wait state");
    a_pin_enable: assert property (disable iff (srst)
        wr_any && paddr == 12'h004 |=> compare_one_out_en == $past(pwdata[7]))
        else $error("pin enable does not follow control write");
    a_unmapped_err: assert property (disable iff (srst)
        psel && penable && paddr > 12'h024 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_level_hold: assert property (disable iff (srst) age == 2'h3 && eq_mode |-> compare_one_out_pin == c1[0])
        else $error("pin one not held at equal level");
    a_pin2_quiet: assert property (disable iff (srst) age == 2'h3 && one_mode |-> $stable(compare_two_out_pin))
        else $error("pin two moved in one-pulse mode");
    c_irq: cover property (disable iff (srst) $rose(irq_request));
    c_wake: cover property (disable iff (srst) $rose(wake_from_wait));
    c_pulse: cover property (disable iff (srst) $rose(compare_one_out_pin));
endmodule // t16pm_timer_props

bind t16pm_timer t16pm_timer_props u_props (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .compare_one_out_pin(compare_one_out_pin), .compare_one_out_en(compare_one_out_en),
    .compare_two_out_pin(compare_two_out_pin), .cpu_irq_mask(cpu_irq_mask), .wait_state(wait_state),
    .irq_request(irq_request), .wake_from_wait(wake_from_wait));

// ---- verif/tb_timer16_pulse_pwm_modes.sv ----
// Self-checking bench for the pulse/PWM timer over APB.
// Pin stimulus and pulse measurement come from t16pm_pin_model.
module tb_timer16_pulse_pwm_modes;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, a, b;
    logic cpu_irq_mask = 0, wait_state = 0, halt_state = 0, trig = 0, cap2 = 0, ext_run = 0;
    wire [31:0] prdata;
    wire pready, pslverr, tpin, cpin, epin, p1, e1, p2, e2, irq, wake;
    int failures = 0, total_checks = 0, high_len, low_len, rises, dv, r;
    initial forever #4 core_clk = ~core_clk;
    t16pm_timer uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_capture_one_pin(tpin), .capture_two_pin(cpin), .external_tick_pin(epin),
        .compare_one_out_pin(p1), .compare_one_out_en(e1), .compare_two_out_pin(p2), .compare_two_out_en(e2),
        .cpu_irq_mask(cpu_irq_mask), .wait_state(wait_state), .halt_state(halt_state),
        .irq_request(irq), .wake_from_wait(wake));
    t16pm_pin_model u_pins (.core_clk(core_clk), .trig_level(trig), .cap2_level(cap2), .ext_run(ext_run),
        .compare_one_out_pin(p1), .trigger_capture_one_pin(tpin), .capture_two_pin(cpin),
        .external_tick_pin(epin), .high_len(high_len), .low_len(low_len), .rises(rises));
    task results;
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_in(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
    endtask
    task rdchk(input string name, input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(name, exp, rd);
    endtask
    task wait_rises(input int k);
        int s, n;
        s = rises;
        n = 0;
        while (rises < s + k && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20000) begin
            failures++;
            results();
        end
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        rdchk("cmp2_hi", 12'h018, 32'h80);
        rdchk("cmp2_lo", 12'h01C, 32'h00);
        // Period set before the free-running count passes it
        apb(1, 12'h018, 32'h0);
        apb(1, 12'h01C, 32'h20);
        apb(1, 12'h004, 32'h90);
        rdchk("ctrl1", 12'h000, 32'h0);
        rdchk("cmp1_hi", 12'h010, 32'h80);
        apb(1, 12'h010, 32'h0);
        apb(1, 12'h014, 32'h3);
        apb(1, 12'h030, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, err});
        apb(1, 12'h000, 32'h01);
        for (int s = 0; s < 4; s++) begin
            dv = (s == 1) ? 2 : (s == 0) ? 4 : 8;
            ext_run <= (s == 3);
            trig <= ~trig;
            apb(1, 12'h004, 32'h91 | (s << 2) | ((s & 1) << 5));
            apb(1, 12'h008, 32'h1F);
            wait_rises(3);
            check("pwm_high", (32'h20 - 3) * dv, high_len);
            check("pwm_low", (3 + 5) * dv, low_len);
            rdchk("pwm_flags", 12'h008, 32'h11);
        end
        ext_run <= 1'b0;
        apb(1, 12'h004, 32'h94);
        wait_rises(2);
        apb(1, 12'h01C, 32'h10);
        wait_rises(1);
        check("buffered_old", (32'h20 - 3) * 2, high_len);
        wait_rises(1);
        check("buffered_new", (32'h10 - 3) * 2, high_len);
        apb(1, 12'h018, 32'h01);
        wait_rises(2);
        check("locked", (32'h10 - 3) * 2, high_len);
        apb(1, 12'h01C, 32'h20);
        wait_rises(2);
        check("unlocked", (32'h120 - 3) * 2, high_len);
        apb(1, 12'h000, 32'h05);
        repeat (40) @(posedge core_clk);
        check("equal_level", 32'h1, {31'h0, p1});
        apb(1, 12'h014, 32'h10);
        // Park the pin low with equal levels so the trigger shows as a rise
        apb(1, 12'h000, 32'h02);
        apb(1, 12'h004, 32'hA4);
        check("equal_low", 32'h0, {31'h0, p1});
        apb(1, 12'h000, 32'h06);
        apb(1, 12'h008, 32'h1F);
        trig <= 1'b1;
        wait_rises(1);
        repeat (60) @(posedge core_clk);
        check_in("pulse_len", (32'h10 + 4) * 2, (32'h10 + 6) * 2, high_len);
        apb(0, 12'h008, 32'h0);
        check("op_flags", 32'h1, rd & 32'h5);
        r = rises;
        trig <= 1'b0;
        repeat (40) @(posedge core_clk);
        apb(1, 12'h000, 32'h04);
        trig <= 1'b1;
        repeat (40) @(posedge core_clk);
        check("wrong_edge", r, rises);
        trig <= 1'b0;
        wait_rises(1);
        cap2 <= 1'b1;
        repeat (8) @(posedge core_clk);
        cap2 <= 1'b0;
        repeat (700) @(posedge core_clk);
        apb(0, 12'h008, 32'h0);
        check("op_cap2_cmp2", 32'hA, rd & 32'hE);
        apb(1, 12'h000, 32'h84);
        repeat (2) @(posedge core_clk);
        check("irq_on", 32'h1, {31'h0, irq});
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("irq_masked", 32'h0, {31'h0, irq});
        cpu_irq_mask <= 1'b0;
        wait_state <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("wake", 32'h1, {31'h0, wake});
        wait_state <= 1'b0;
        apb(1, 12'h008, 32'h1F);
        repeat (2) @(posedge core_clk);
        check("irq_cleared", 32'h0, {31'h0, irq});
        halt_state <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(0, 12'h00C, 32'h0);
        a = rd;
        cap2 <= 1'b1;
        repeat (8) @(posedge core_clk);
        cap2 <= 1'b0;
        repeat (20) @(posedge core_clk);
        rdchk("halt_count", 12'h00C, a);
        rdchk("halt_no_flag", 12'h008, 32'h0);
        halt_state <= 1'b0;
        repeat (20) @(posedge core_clk);
        apb(0, 12'h00C, 32'h0);
        b = rd;
        check("count_resumes", 32'h1, {31'h0, b !== a});
        apb(0, 12'h008, 32'h0);
        check("halt_exit_flag", 32'h2, rd & 32'h2);
        results();
    end
endmodule // tb_timer16_pulse_pwm_modes
